// [pkg/app_defines.svh]
`ifndef APP_DEFINES_SVH
`define APP_DEFINES_SVH
`define APP_CLK_MHZ 20
`define APP_INIT_US 10
`define APP_CLK_TO_NS 2000
`define APP_SAMPLE_W 24
`define APP_PWM_W 6
`define APP_FIFO_DEPTH 16
`define APP_BITS_HALF 6'h20
`define APP_BCLK_HALF_CYC 4
`define APP_TICK_NORMAL 8
`define APP_TICK_DOUBLE 16
`define APP_OSR_NORMAL 8
`define APP_OSR_DOUBLE 4
`define APP_SHIFT_NORMAL 3
`define APP_SHIFT_DOUBLE 2
`define APP_FMT_RJ_LAST 3'h2
`define APP_FMT_I2S_LAST 3'h5
`define APP_FMT_DSP 3'h7
`define APP_SY_W 12
`define APP_SY_DATA 0
`define APP_SY_BCLK 1
`define APP_SY_FCLK 2
`define APP_SY_RST 3
`define APP_SY_PWR 4
`define APP_SY_PLL 5
`define APP_SY_DBL 6
`define APP_SY_MS 7
`define APP_SY_MUTE 8
`define APP_SY_FMT 9
`endif

// [pkg/app_pkg.sv]
`include "app_defines.svh"
package app_pkg;
  typedef enum logic [2:0] {ST_DOWN, ST_RESET, ST_INIT, ST_RUN, ST_FAULT}
    app_state_e;
  typedef enum logic [1:0] {OUT_HARD, OUT_QUIET, OUT_AUDIO} app_out_e;
  typedef struct packed {
    logic [`APP_SAMPLE_W-1:0] l;
    logic [`APP_SAMPLE_W-1:0] r;
  } app_stereo_s;
  typedef struct packed {
    app_state_e st;
    logic [`APP_SY_W-1:0] sy1;
    logic [`APP_SY_W-1:0] sy2;
    logic ms;
    logic dbl;
    logic [2:0] fmt;
    logic [15:0] tmr;
    logic [7:0] wdog;
    logic bclk_q;
    logic fclk_q;
    logic synced;
    logic [5:0] bcnt;
    logic [3:0] subcnt;
    logic [`APP_SAMPLE_W-1:0] shreg;
    app_stereo_s word;
    logic push;
    logic perr;
    logic [2:0] phase;
    app_stereo_s cur;
    logic signed [`APP_SAMPLE_W:0] stepl;
    logic signed [`APP_SAMPLE_W:0] stepr;
    logic signed [`APP_SAMPLE_W:0] accl;
    logic signed [`APP_SAMPLE_W:0] accr;
    logic [`APP_PWM_W-1:0] pcnt;
    logic [1:0] gdiv;
    logic gbclk;
    logic [5:0] gbit;
    logic mclk;
    logic valid;
  } app_main_s;
endpackage

// [hdl/app_fifo.sv]
`timescale 1ns/1ps
`include "app_defines.svh"
module app_fifo #(
  parameter int WIDTH = 2 * `APP_SAMPLE_W,
  parameter int DEPTH = `APP_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  import app_pkg::*;
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } app_fifo_s;
  app_fifo_s s_r, s_nxt;
  logic full, empty;

  assign full = (s_r.wp[AW] != s_r.rp[AW]) &&
                (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]);
  assign empty = (s_r.wp == s_r.rp);
  assign o_ready = ~full;
  assign o_valid = ~empty;
  assign o_data = s_r.mem[s_r.rp[AW-1:0]];

  always_comb
  begin
    s_nxt = s_r;
    if (i_valid && !full)
    begin
      s_nxt.mem[s_r.wp[AW-1:0]] = i_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (i_ready && !empty)
      s_nxt.rp = s_r.rp + 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule

// [hdl/app_pwm_chan.sv]
`timescale 1ns/1ps
`include "app_defines.svh"
module app_pwm_chan #(
  parameter int SW = `APP_SAMPLE_W,
  parameter int PW = `APP_PWM_W
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic signed [SW-1:0] i_sample,
  input wire logic [PW-1:0] i_cnt,
  input wire app_pkg::app_out_e i_mode,
  output logic o_pos,
  output logic o_neg
);
  import app_pkg::*;
  localparam int EW = SW + 4;
  localparam int SH = SW - PW;
  localparam logic signed [EW-1:0] MAXV = EW'((1 <<< (SW - 1)) - 1);
  localparam logic signed [EW-1:0] MINV = EW'(-(1 <<< (SW - 1)));
  localparam logic [PW-1:0] HALF = PW'(1 <<< (PW - 1));
  typedef struct packed {
    logic signed [EW-1:0] e1;
    logic signed [EW-1:0] e2;
    logic signed [EW-1:0] e3;
    logic signed [EW-1:0] e4;
    logic [PW-1:0] duty;
    logic pos;
    logic neg;
  } app_chan_s;
  app_chan_s s_r, s_nxt;
  logic signed [EW-1:0] y, qv, e;
  logic signed [PW-1:0] q;
  logic pwm;

  always_comb
  begin
    s_nxt = s_r;
    // R10 fourth-order error feedback
    y = EW'(i_sample) + (s_r.e1 <<< 2) - (s_r.e2 <<< 2) - (s_r.e2 <<< 1)
        + (s_r.e3 <<< 2) - s_r.e4;
    if (y > MAXV)
      qv = MAXV;
    else if (y < MINV)
      qv = MINV;
    else
      qv = y;
    q = PW'(qv >>> SH);
    e = qv - (EW'(q) <<< SH);
    if (&i_cnt)
    begin
      if (i_mode == OUT_AUDIO)
      begin
        s_nxt.e1 = e;
        s_nxt.e2 = s_r.e1;
        s_nxt.e3 = s_r.e2;
        s_nxt.e4 = s_r.e3;
        s_nxt.duty = {~q[PW-1], q[PW-2:0]};
      end
      else
      begin
        // R18 zero value at half duty
        s_nxt.e1 = '0;
        s_nxt.e2 = '0;
        s_nxt.e3 = '0;
        s_nxt.e4 = '0;
        s_nxt.duty = HALF;
      end
    end
    // R10 two-state complementary drive
    pwm = (i_cnt < s_r.duty);
    // R22 hard mute overrides all
    if (i_mode == OUT_HARD)
    begin
      s_nxt.pos = 1'b0;
      s_nxt.neg = 1'b1;
    end
    else
    begin
      s_nxt.pos = pwm;
      s_nxt.neg = ~pwm;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      s_r <= '0;
      s_r.neg <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign o_pos = s_r.pos;
  assign o_neg = s_r.neg;
endmodule

// [hdl/app_core.sv]
// Overview of operation
// R1 - master mode drives 256/64/1 Fs clocks
// R2 - slave mode: master clock output low
// R3 - slave clocks must track master clock
// R4 - normal speed reference clock rates fixed
// R5 - double speed slave clock rates fixed
// R6 - 32 kHz only without double speed
// R7 - bit/frame pins output in master mode
// R8 - lost lock drops both valid flags
// R9 - interpolate 8x normal, 4x double speed
// R10 - fourth-order shaper then two-state PWM
// R11 - format pin change restarts initialization
// R12 - power up: flags low, hard mute
// R13 - reset required when mode selects change
// R14 - reset held: hard mute, flags low
// R15 - reset rise with power on: initialize
// R16 - power down stops PLL and oscillator
// R17 - both low: stay powered down, muted
// R18 - mute low gives 50% duty zero
// R19 - double speed taken at reset release
// R20 - valid flags high when outputs valid
// R21 - clock errors mute, then reinitialize
// R22 - hard mute wins over quiet mute
`timescale 1ns/1ps
`include "app_defines.svh"
module app_core #(
  parameter int PW = `APP_PWM_W,
  parameter int DEPTH = `APP_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_serial_audio_in,
  input wire logic i_shift_clk,
  input wire logic i_frame_clk,
  input wire logic i_chip_reset_n,
  input wire logic i_power_down_n,
  input wire logic i_pll_locked,
  input wire logic i_format_select_bit0,
  input wire logic i_format_select_bit1,
  input wire logic i_format_select_bit2,
  input wire logic i_double_speed_select,
  input wire logic i_master_select,
  input wire logic i_mute_n,
  output logic o_mclk_out,
  output logic o_shift_clk,
  output logic o_shift_clk_oe,
  output logic o_frame_clk,
  output logic o_frame_clk_oe,
  output logic o_osc_enable,
  output logic o_pll_enable,
  output logic o_left_pos_pulse_out,
  output logic o_left_neg_pulse_out,
  output logic o_right_pos_pulse_out,
  output logic o_right_neg_pulse_out,
  output logic o_valid_left,
  output logic o_valid_right
);
  import app_pkg::*;
  localparam int SW = `APP_SAMPLE_W;
  localparam int INIT_CYC = `APP_INIT_US * `APP_CLK_MHZ;
  localparam int TO_CYC = `APP_CLK_TO_NS * `APP_CLK_MHZ / 1000;
  localparam logic [15:0] INIT_MAX = 16'(INIT_CYC - 1);
  localparam logic [7:0] WD_MAX = 8'(TO_CYC);
  localparam logic [1:0] GDIV_MAX = 2'(`APP_BCLK_HALF_CYC - 1);

  app_main_s s_r, s_nxt;
  app_stereo_s fifo_out;
  app_out_e omode;
  logic [`APP_SY_W-1:0] pins;
  logic [2:0] fmt_s;
  logic rst_s, pwr_s, pll_s, sbclk, sfclk, sdata;
  logic dsp, rjust, i2s, left_lvl, bedge, fedge, tick, missing, err;
  logic fifo_rdy, fifo_vld, pop, fifo_rst_n;
  logic [3:0] tick_lim;
  logic [2:0] ph_lim;
  logic [5:0] cap_at;
  logic [4:0] nbits;

  function automatic logic [SW-1:0] align(input logic [SW-1:0] sh,
                                          input logic [4:0] n);
    if (n == 5'd16)
      align = {sh[15:0], 8'h00};
    else if (n == 5'd20)
      align = {sh[19:0], 4'h0};
    else
      align = sh;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin sampling and decode
  assign pins = {i_format_select_bit2, i_format_select_bit1,
                 i_format_select_bit0, i_mute_n, i_master_select,
                 i_double_speed_select, i_pll_locked, i_power_down_n,
                 i_chip_reset_n, i_frame_clk, i_shift_clk,
                 i_serial_audio_in};
  assign rst_s = s_r.sy2[`APP_SY_RST];
  assign pwr_s = s_r.sy2[`APP_SY_PWR];
  assign pll_s = s_r.sy2[`APP_SY_PLL];
  assign fmt_s = s_r.sy2[`APP_SY_FMT+:3];
  assign sdata = s_r.sy2[`APP_SY_DATA];
  // R7 own clocks in master, pins in slave
  assign sbclk = s_r.ms ? s_r.gbclk : s_r.sy2[`APP_SY_BCLK];
  assign sfclk = s_r.ms ? s_r.gbit[5] : s_r.sy2[`APP_SY_FCLK];
  assign dsp = (s_r.fmt == `APP_FMT_DSP);
  assign rjust = (s_r.fmt <= `APP_FMT_RJ_LAST);
  assign i2s = !rjust && (s_r.fmt <= `APP_FMT_I2S_LAST);
  assign left_lvl = ~i2s;
  assign nbits = (s_r.fmt == 3'h1 || s_r.fmt == 3'h4) ? 5'd20 :
                 (s_r.fmt == 3'h2 || s_r.fmt == 3'h5) ? 5'd24 : 5'd16;
  assign cap_at = {1'b0, nbits} + {5'h00, i2s};
  assign bedge = dsp ? (s_r.bclk_q & ~sbclk) : (~s_r.bclk_q & sbclk);
  assign fedge = s_r.fclk_q ^ sfclk;
  // R6 double speed only halves the ratio
  assign tick_lim = s_r.dbl ? 4'(`APP_TICK_DOUBLE - 1) :
                              4'(`APP_TICK_NORMAL - 1);
  // R9 8x normal, 4x double speed
  assign ph_lim = s_r.dbl ? 3'(`APP_OSR_DOUBLE - 1) :
                            3'(`APP_OSR_NORMAL - 1);
  assign tick = bedge && (s_r.subcnt == tick_lim);
  assign pop = tick && (s_r.st == ST_RUN) && (s_r.phase == 3'h0) && fifo_vld;
  // R21 missing clock watchdog
  assign missing = ~s_r.ms && (s_r.wdog == WD_MAX);
  // R8 lost lock is an error
  assign err = ~pll_s | missing | s_r.perr | (s_r.push & ~fifo_rdy);
  assign fifo_rst_n = i_rst_n && (s_r.st == ST_RUN);

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic signed [SW:0] dl;
    logic signed [SW:0] dr;
    logic go_init;
    app_stereo_s nw;
    dl = '0;
    dr = '0;
    go_init = 1'b0;
    nw = fifo_vld ? fifo_out : s_r.cur;
    s_nxt = s_r;
    s_nxt.sy1 = pins;
    s_nxt.sy2 = s_r.sy1;
    s_nxt.push = 1'b0;
    s_nxt.perr = 1'b0;
    s_nxt.bclk_q = sbclk;
    s_nxt.fclk_q = sfclk;
    s_nxt.pcnt = s_r.pcnt + 1'b1;

    // R1 master clock generation
    if (s_r.ms && s_r.st != ST_DOWN)
    begin
      s_nxt.mclk = ~s_r.mclk;
      s_nxt.gdiv = s_r.gdiv + 2'h1;
      if (s_r.gdiv == GDIV_MAX)
      begin
        s_nxt.gdiv = 2'h0;
        s_nxt.gbclk = ~s_r.gbclk;
        if (s_r.gbclk)
          s_nxt.gbit = s_r.gbit + 6'h01;
      end
    end
    else
    begin
      // R2 master clock output low in slave
      s_nxt.mclk = 1'b0;
      s_nxt.gdiv = 2'h0;
      s_nxt.gbclk = 1'b0;
      s_nxt.gbit = 6'h00;
    end

    if (bedge)
      s_nxt.wdog = 8'h00;
    else if (s_r.wdog != WD_MAX)
      s_nxt.wdog = s_r.wdog + 8'h01;

    // serial receiver
    if (bedge)
    begin
      s_nxt.shreg = {s_r.shreg[SW-2:0], sdata};
      s_nxt.bcnt = s_r.bcnt + 6'h01;
      s_nxt.subcnt = (s_r.subcnt == tick_lim) ? 4'h0 : s_r.subcnt + 4'h1;
      if (!rjust && s_nxt.bcnt == cap_at)
      begin
        if (sfclk == left_lvl)
          s_nxt.word.l = align(s_nxt.shreg, nbits);
        else
          s_nxt.word.r = align(s_nxt.shreg, nbits);
      end
    end
    if (fedge)
    begin
      // R21 phase error: wrong bit count
      if (s_r.synced && s_r.bcnt != `APP_BITS_HALF)
        s_nxt.perr = 1'b1;
      s_nxt.bcnt = bedge ? 6'h01 : 6'h00;
      s_nxt.synced = 1'b1;
      if (rjust)
      begin
        if (s_r.fclk_q == left_lvl)
          s_nxt.word.l = align(s_nxt.shreg, nbits);
        else
          s_nxt.word.r = align(s_nxt.shreg, nbits);
      end
      if (s_r.synced && s_r.fclk_q != left_lvl && s_r.st == ST_RUN)
        s_nxt.push = 1'b1;
    end

    // R9 linear-phase linear interpolation
    if (tick && s_r.st == ST_RUN)
    begin
      s_nxt.phase = (s_r.phase == ph_lim) ? 3'h0 : s_r.phase + 3'h1;
      if (s_r.phase == 3'h0)
      begin
        dl = {nw.l[SW-1], nw.l} - {s_r.cur.l[SW-1], s_r.cur.l};
        dr = {nw.r[SW-1], nw.r} - {s_r.cur.r[SW-1], s_r.cur.r};
        s_nxt.stepl = s_r.dbl ? dl >>> `APP_SHIFT_DOUBLE :
                                dl >>> `APP_SHIFT_NORMAL;
        s_nxt.stepr = s_r.dbl ? dr >>> `APP_SHIFT_DOUBLE :
                                dr >>> `APP_SHIFT_NORMAL;
        s_nxt.accl = {s_r.cur.l[SW-1], s_r.cur.l};
        s_nxt.accr = {s_r.cur.r[SW-1], s_r.cur.r};
        s_nxt.cur = nw;
      end
      else
      begin
        s_nxt.accl = s_r.accl + s_r.stepl;
        s_nxt.accr = s_r.accr + s_r.stepr;
      end
    end

    // control sequence
    case (s_r.st)
      ST_DOWN, ST_RESET:
        // R15 release starts initialization
        go_init = 1'b1;
      ST_INIT:
        if (s_r.tmr == INIT_MAX)
          s_nxt.st = ST_RUN;
        else
          s_nxt.tmr = s_r.tmr + 16'h0001;
      ST_RUN:
        // R11 format change restarts
        if (fmt_s != s_r.fmt)
          go_init = 1'b1;
        else if (err)
          s_nxt.st = ST_FAULT;
      ST_FAULT:
        // R21 reinitialize once clocks return
        go_init = pll_s & ~missing;
      default:
        s_nxt.st = ST_DOWN;
    endcase
    if (go_init)
    begin
      s_nxt.st = ST_INIT;
      s_nxt.tmr = 16'h0000;
      // R19 mode selects latched on release
      s_nxt.ms = s_r.sy2[`APP_SY_MS];
      s_nxt.dbl = s_r.sy2[`APP_SY_DBL];
      if (!s_r.sy2[`APP_SY_MS])
        s_nxt.mclk = 1'b0;
      s_nxt.fmt = fmt_s;
      s_nxt.synced = 1'b0;
      s_nxt.wdog = 8'h00;
      s_nxt.phase = 3'h0;
      s_nxt.cur = '0;
      s_nxt.accl = '0;
      s_nxt.accr = '0;
    end
    // R17 power down holds off
    if (!pwr_s)
      s_nxt.st = ST_DOWN;
    // R14 reset held
    else if (!rst_s)
      s_nxt.st = ST_RESET;
    // R20 valid only in operation
    s_nxt.valid = (s_nxt.st == ST_RUN);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // sample buffer and output channels
  app_fifo #(
    .WIDTH($bits(app_stereo_s)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(fifo_rst_n),
    .i_valid(s_r.push),
    .o_ready(fifo_rdy),
    .i_data(s_r.word),
    .o_valid(fifo_vld),
    .i_ready(pop),
    .o_data(fifo_out)
  );

  // R12 hard mute outside operation
  assign omode = (s_r.st != ST_RUN) ? OUT_HARD :
                 s_r.sy2[`APP_SY_MUTE] ? OUT_AUDIO : OUT_QUIET;

  app_pwm_chan #(
    .SW(SW),
    .PW(PW)
  ) u_left (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_sample(s_r.accl[SW-1:0]),
    .i_cnt(s_r.pcnt),
    .i_mode(omode),
    .o_pos(o_left_pos_pulse_out),
    .o_neg(o_left_neg_pulse_out)
  );

  app_pwm_chan #(
    .SW(SW),
    .PW(PW)
  ) u_right (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_sample(s_r.accr[SW-1:0]),
    .i_cnt(s_r.pcnt),
    .i_mode(omode),
    .o_pos(o_right_pos_pulse_out),
    .o_neg(o_right_neg_pulse_out)
  );

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_mclk_out = s_r.mclk;
  assign o_shift_clk = s_r.gbclk;
  assign o_shift_clk_oe = s_r.ms;
  assign o_frame_clk = s_r.gbit[5];
  assign o_frame_clk_oe = s_r.ms;
  // R16 oscillator and PLL off
  assign o_osc_enable = pwr_s;
  assign o_pll_enable = pwr_s;
  assign o_valid_left = s_r.valid;
  assign o_valid_right = s_r.valid;
endmodule

// [dv/app_core_chk.sv]
`timescale 1ns/1ps
module app_core_chk #(
  parameter int PW = 6,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_chip_reset_n,
  input wire logic i_power_down_n,
  input wire logic i_pll_locked,
  input wire logic i_format_select_bit0,
  input wire logic i_format_select_bit1,
  input wire logic i_format_select_bit2,
  input wire logic i_mute_n,
  input wire logic o_mclk_out,
  input wire logic o_shift_clk_oe,
  input wire logic o_frame_clk_oe,
  input wire logic o_osc_enable,
  input wire logic o_pll_enable,
  input wire logic o_left_pos_pulse_out,
  input wire logic o_left_neg_pulse_out,
  input wire logic o_right_pos_pulse_out,
  input wire logic o_right_neg_pulse_out,
  input wire logic o_valid_left,
  input wire logic o_valid_right
);
  logic [15:0] low_r;
  logic [15:0] low_nxt;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // cycles spent with valid low
  always_comb
  begin
    low_nxt = low_r;
    if (o_valid_left)
      low_nxt = 16'h0;
    else if (low_r != 16'hffff)
      low_nxt = low_r + 16'h1;
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      low_r <= 16'h0;
    else
      low_r <= low_nxt;
  end
////////////////////////////////////////
  a_slave_mclk_low: assert property (
    !o_shift_clk_oe |-> !o_mclk_out) else $error("mclk active in slave");
  a_pin_dir_pair: assert property (
    o_shift_clk_oe == o_frame_clk_oe) else $error("pin enables differ");
  a_master_mclk_run: assert property (
    o_valid_left && $past(o_valid_left) && o_shift_clk_oe
    |-> $changed(o_mclk_out)) else $error("mclk not toggling");
  a_pwm_two_state: assert property (
    o_left_neg_pulse_out == !o_left_pos_pulse_out &&
    o_right_neg_pulse_out == !o_right_pos_pulse_out)
    else $error("pwm pair not complementary");
  a_reset_hard_mute: assert property (
    !i_chip_reset_n [*6] |-> !o_left_pos_pulse_out && o_left_neg_pulse_out
    && !o_right_pos_pulse_out && !o_valid_left)
    else $error("no hard mute in reset");
  a_pwr_stops_osc: assert property (
    !i_power_down_n [*4] |-> !o_osc_enable && !o_pll_enable)
    else $error("osc or pll still enabled");
  a_lock_loss_flags: assert property (
    !i_pll_locked [*6] |-> !o_valid_left && !o_valid_right)
    else $error("valid high without lock");
  a_valid_pair: assert property (
    o_valid_left == o_valid_right) else $error("valid flags differ");
  a_fmt_restart: assert property (
    o_valid_left && $changed({i_format_select_bit2, i_format_select_bit1,
    i_format_select_bit0}) |-> ##[1:6] !o_valid_left)
    else $error("format change kept running");
  a_init_length: assert property (
    $rose(o_valid_left) |-> low_r >= 16'h00c8)
    else $error("init interval too short");
  c_up: cover property ($rose(o_valid_left));
  c_drop: cover property ($fell(o_valid_left));
  c_master: cover property (o_valid_left && o_shift_clk_oe);
  c_quiet: cover property (o_valid_left && !i_mute_n);
endmodule
bind app_core app_core_chk #(.PW(PW), .DEPTH(DEPTH)) i_chk (
  .i_clk, .i_rst_n, .i_chip_reset_n, .i_power_down_n, .i_pll_locked,
  .i_format_select_bit0, .i_format_select_bit1, .i_format_select_bit2,
  .i_mute_n, .o_mclk_out, .o_shift_clk_oe, .o_frame_clk_oe, .o_osc_enable,
  .o_pll_enable, .o_left_pos_pulse_out, .o_left_neg_pulse_out,
  .o_right_pos_pulse_out, .o_right_neg_pulse_out, .o_valid_left,
  .o_valid_right);

// [dv/app_src.sv]
`timescale 1ns/1ps
module app_src (
  input wire logic i_en,
  output logic o_sclk,
  output logic o_lrclk,
  output logic o_data
);
  logic [5:0] bit_r;
  logic [31:0] pat;
  initial
  begin
    o_sclk = 1'b0;
    o_lrclk = 1'b1;
    o_data = 1'b0;
    bit_r = 6'h0;
    pat = 32'h5a3c_0f96;
  end
  // bit clock at one fixed rate
  always #200 if (i_en) o_sclk = ~o_sclk;
  // frame toggles every 32 bit clocks
  always @(negedge o_sclk)
  begin
    bit_r <= bit_r + 6'h1;
    if (bit_r == 6'h1f)
      o_lrclk <= 1'b0;
    else if (bit_r == 6'h3f)
      o_lrclk <= 1'b1;
    o_data <= pat[bit_r[4:0]];
  end
endmodule

// [dv/app_core_bench.sv]
`timescale 1ns/1ps
module app_core_bench;
  import app_pkg::*;
  logic clk = 1'b0;
  logic rst_n, crst_n, pwr_n, lock, dbl, ms, mute_n, src_en;
  logic [2:0] fmt;
  logic mclk, sck, sck_oe, fck, fck_oe, osc, pll, lp, ln, rp, rn, vl, vr;
  logic s_sck, s_fck, s_dat;
  int n_mismatch = 0;
  int cmp_count = 0;
  int tmo = 0;
  always #25 clk = ~clk;
  app_src i_src (.i_en(src_en), .o_sclk(s_sck), .o_lrclk(s_fck),
    .o_data(s_dat));
  app_core i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_serial_audio_in(s_dat),
    .i_shift_clk(sck_oe ? sck : s_sck), .i_frame_clk(fck_oe ? fck : s_fck),
    .i_chip_reset_n(crst_n), .i_power_down_n(pwr_n), .i_pll_locked(lock),
    .i_format_select_bit0(fmt[0]), .i_format_select_bit1(fmt[1]),
    .i_format_select_bit2(fmt[2]), .i_double_speed_select(dbl),
    .i_master_select(ms), .i_mute_n(mute_n), .o_mclk_out(mclk),
    .o_shift_clk(sck), .o_shift_clk_oe(sck_oe), .o_frame_clk(fck),
    .o_frame_clk_oe(fck_oe), .o_osc_enable(osc), .o_pll_enable(pll),
    .o_left_pos_pulse_out(lp), .o_left_neg_pulse_out(ln),
    .o_right_pos_pulse_out(rp), .o_right_neg_pulse_out(rn),
    .o_valid_left(vl), .o_valid_right(vr));
////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wait_v(input logic e, input int mx, output int n);
    n = 0;
    while (vl !== e && n < mx)
    begin
      cyc(1);
      n++;
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
////////////////////////////////////////
  task automatic t_up();
    int n;
    cyc(1);
    chk({lp, ln, rp, rn, vl, vr, mclk}, 7'h28);
    pwr_n = 1'b1;
    crst_n = 1'b1;
    lock = 1'b1;
    src_en = 1'b1;
    wait_v(1'b1, 400, n);
    chk(vr, 1'b1);
    chk(n >= 200, 1'b1);
    chk({sck_oe, fck_oe, mclk, osc, pll}, 5'h03);
    $display("test power_up done");
  endtask
  task automatic t_mute();
    int n, hl, hr;
    mute_n = 1'b0;
    cyc(70);
    hl = 0;
    hr = 0;
    for (int i = 0; i < 128; i++)
    begin
      hl += lp;
      hr += rp;
      cyc(1);
    end
    chk(hl[15:0], 16'h0040);
    chk(hr[15:0], 16'h0040);
    crst_n = 1'b0;
    cyc(6);
    chk({lp, ln, vl}, 3'h2);
    crst_n = 1'b1;
    mute_n = 1'b1;
    wait_v(1'b1, 400, n);
    chk(vl, 1'b1);
    $display("test mute done");
  endtask
  task automatic t_faults();
    int n;
    lock = 1'b0;
    wait_v(1'b0, 10, n);
    cyc(1);
    chk({vl, vr, lp, ln}, 4'h1);
    lock = 1'b1;
    wait_v(1'b1, 400, n);
    chk(vl, 1'b1);
    src_en = 1'b0;
    wait_v(1'b0, 60, n);
    cyc(1);
    chk({vl, lp, ln}, 3'h1);
    src_en = 1'b1;
    wait_v(1'b1, 400, n);
    chk(vl, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      fmt[i] = ~fmt[i];
      wait_v(1'b0, 10, n);
      chk(vl, 1'b0);
      wait_v(1'b1, 400, n);
      chk(vl, 1'b1);
    end
    $display("test faults done");
  endtask
  task automatic t_master();
    int n, r;
    logic m0, p;
    crst_n = 1'b0;
    ms = 1'b1;
    dbl = 1'b1;
    src_en = 1'b0;
    cyc(6);
    crst_n = 1'b1;
    wait_v(1'b1, 400, n);
    chk({vl, sck_oe, fck_oe}, 3'h7);
    m0 = mclk;
    cyc(1);
    chk(mclk, !m0);
    r = 0;
    p = sck;
    for (int i = 0; i < 64; i++)
    begin
      cyc(1);
      r += (sck && !p);
      p = sck;
    end
    chk(r[15:0], 16'h0008);
    r = 0;
    p = fck;
    for (int i = 0; i < 512; i++)
    begin
      cyc(1);
      r += (fck != p);
      p = fck;
    end
    chk(r[15:0], 16'h0002);
    $display("test master done");
  endtask
  task automatic t_power();
    int n;
    crst_n = 1'b0;
    pwr_n = 1'b0;
    cyc(6);
    chk({osc, pll, lp, ln, vl}, 5'h02);
    pwr_n = 1'b1;
    crst_n = 1'b1;
    wait_v(1'b1, 400, n);
    chk({osc, pll, vl}, 3'h7);
    $display("test power_down done");
  endtask
  task automatic t_audio();
    int hl, hr;
    cyc(1800);
    hl = 0;
    hr = 0;
    for (int i = 0; i < 512; i++)
    begin
      hl += lp;
      hr += rp;
      cyc(1);
    end
    chk(hl > 256, 1'b1);
    chk(hr > 256, 1'b1);
    chk({vl, vr}, 2'h3);
    $display("test audio done");
  endtask
////////////////////////////////////////
  always @(posedge clk)
  begin
    tmo++;
    if (tmo == 30000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial
  begin
    {rst_n, crst_n, pwr_n, lock, dbl, ms, src_en} = 7'h00;
    mute_n = 1'b1;
    fmt = 3'h0;
    cyc(12);
    rst_n = 1'b1;
    t_up();
    t_audio();
    t_mute();
    t_faults();
    t_power();
    t_master();
    print_verdict();
  end
endmodule
